//--- verilog/stpc_top.sv
// APB register bank for the lane transmit configuration and the peripheral control words.
// Assumes a zero-wait APB master and macro-side inputs synchronous to pclk.
//
// How it works
// (RULE1) Test sequence code picks off, alternating, three PRBS, or user pattern; 11x reserved.
// (RULE2) Short PRBS comes from a seven-stage LFSR, x^7 + x^6 + 1.
// (RULE3) Medium PRBS comes from a twenty-three stage LFSR, x^23 + x^18 + 1.
// (RULE4) Long PRBS comes from a thirty-one stage LFSR, x^31 + x^28 + 1.
// (RULE5) User code repeats a twenty-bit pattern from its own register, default 0x66666.
// (RULE6) Alternating code toggles every unit interval, period two intervals.
// (RULE7) Loopback code: off, reserved, loop with driver off, loop with driver on.
// (RULE8) Software sets sync master on single lanes or the lowest lane of an aggregate.
// (RULE9) Tap weights load only while lane byte clock and update bit are both high.
// (RULE10) Post-cursor code is sign and four-bit magnitude in 2.5 percent steps.
// (RULE11) Pre-cursor code gives zero down to -17.5 percent in 2.5 percent steps.
// (RULE12) Polarity swap bit exchanges the positive and negative lane outputs.
// (RULE13) Rate field selects full, half, quarter or eighth rate to the macro.
// (RULE14) Transmitter-on bit switches the lane transmitter off at 0, on at 1.
// (RULE15) Software always programs parallel width code 010b, twenty-bit interface.
// (RULE16) Identification word is constant; writes to it change nothing.
// (RULE17) Identification word layout: scheme 01, unit, function, release, major, custom, minor.
// (RULE18) Module control bits in the control word are writable only while peripheral on.
// (RULE19) Writing one to restore sets local traffic back to accepted.
// (RULE20) Local status drops to discard while module reset is low; 1 means accept.
// (RULE21) Peripheral on resets to 0; while 0 the logical layer neither sends nor accepts.
// (RULE22) Software turns the peripheral on last during bring-up.
// (RULE23) Emulation soft resets to 0 and free resets to 1.
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
module stpc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [stpc_pkg::NUM_LANES-1:0] byte_clk,
  input wire logic [stpc_pkg::NUM_LANES-1:0] tx_data,
  input wire logic module_rst_n,
  output logic [stpc_pkg::NUM_LANES-1:0] tx_p,
  output logic [stpc_pkg::NUM_LANES-1:0] tx_n,
  output wire stpc_pkg::stpc_lane_out_t [stpc_pkg::NUM_LANES-1:0] lane_out,
  output logic peripheral_on,
  output logic local_rx_accept,
  output logic emu_soft,
  output logic emu_free,
  output logic [31:0] settings_out
);

  localparam int unsigned NL = stpc_pkg::NUM_LANES;

  stpc_pkg::stpc_lane_cfg_t [NL-1:0] lane_q;
  logic [31:0] set_q;
  logic [19:0] user_q;
  logic peripheral_on_q;
  logic soft_q;
  logic free_q;
  logic local_accept_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic [NL-1:0] pat_bit;
  logic [NL-1:0] txp_q;
  logic [NL-1:0] txn_q;
  logic hit_id;
  logic hit_ctrl;
  logic hit_set;
  logic hit_user;
  logic [NL-1:0] hit_lane;
  logic mapped;
  logic wr_en;
  logic rd_setup;
  logic restore_pulse;

  // Byte lanes of a write merged over the old contents.
  function automatic logic [31:0] merge_f(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
    merge_f = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge_f[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
  endfunction

  function automatic logic [31:0] lane_addr_f(input int unsigned n);
    lane_addr_f = stpc_pkg::ADDR_LANE_BASE + 32'(stpc_pkg::LANE_STRIDE * n);
  endfunction

  always_comb begin
    hit_id = (paddr == stpc_pkg::ADDR_ID);
    hit_ctrl = (paddr == stpc_pkg::ADDR_CTRL);
    hit_set = (paddr == stpc_pkg::ADDR_SET);
    hit_user = (paddr == stpc_pkg::ADDR_USER);
    for (int i = 0; i < NL; i++) begin
      hit_lane[i] = (paddr == lane_addr_f(i));
    end
    mapped = hit_id | hit_ctrl | hit_set | hit_user | (|hit_lane);
  end

  // Writes take effect in the access phase; reads are captured in setup so prdata comes from a flop.
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Restore is a module bit, so it only acts while the peripheral is on.
  assign restore_pulse = wr_en && hit_ctrl && pstrb[0] && pwdata[stpc_pkg::CTRL_RESTORE_BIT] && peripheral_on_q; // [RULE18]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_on_q <= stpc_pkg::CTRL_PERIPHERAL_ON_RST; // [RULE21]
      soft_q <= stpc_pkg::CTRL_SOFT_RST; // [RULE23]
      free_q <= stpc_pkg::CTRL_FREE_RST; // [RULE23]
    end else if (wr_en && hit_ctrl && pstrb[0]) begin
      peripheral_on_q <= pwdata[stpc_pkg::CTRL_PERIPHERAL_ON_BIT];
      soft_q <= pwdata[stpc_pkg::CTRL_SOFT_BIT];
      free_q <= pwdata[stpc_pkg::CTRL_FREE_BIT];
    end
  end

  // Module reset wins over a restore in the same cycle so no packet slips in during reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_accept_q <= stpc_pkg::CTRL_LOCAL_RST;
    end else if (!module_rst_n) begin
      local_accept_q <= 1'b0; // [RULE20]
    end else if (restore_pulse) begin
      local_accept_q <= 1'b1; // [RULE19]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_q <= stpc_pkg::SET_RST;
    end else if (wr_en && hit_set) begin
      set_q <= merge_f(set_q, pwdata, pstrb) & stpc_pkg::SET_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_q <= stpc_pkg::USER_RST; // [RULE5]
    end else if (wr_en && hit_user) begin
      user_q <= 20'(merge_f({12'h000, user_q}, pwdata, pstrb));
    end
  end

  // The width field is stored as written; the 010b setting is left to software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NL; i++) begin
        lane_q[i] <= stpc_pkg::LANE_RST;
      end
    end else begin
      for (int i = 0; i < NL; i++) begin
        if (wr_en && hit_lane[i]) begin
          lane_q[i] <= merge_f(lane_q[i], pwdata, pstrb) & stpc_pkg::LANE_WMASK;
        end
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_id) begin
      rd_mux = stpc_pkg::ID_VALUE; // [RULE16] [RULE17]
    end
    if (hit_ctrl) begin
      rd_mux[stpc_pkg::CTRL_LOCAL_BIT] = local_accept_q;
      rd_mux[stpc_pkg::CTRL_PERIPHERAL_ON_BIT] = peripheral_on_q;
      rd_mux[stpc_pkg::CTRL_SOFT_BIT] = soft_q;
      rd_mux[stpc_pkg::CTRL_FREE_BIT] = free_q;
    end
    if (hit_set) begin
      rd_mux = set_q;
    end
    if (hit_user) begin
      rd_mux = {12'h000, user_q};
    end
    for (int i = 0; i < NL; i++) begin
      if (hit_lane[i]) begin
        rd_mux = lane_q[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      rdata_q <= rd_mux;
    end
  end

  assign prdata = rdata_q;

  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : gen_lane
      stpc_pattern u_pattern (
        .pclk(pclk),
        .presetn(presetn),
        .sel(lane_q[g].test_sequence_select),
        .user_bits(user_q),
        .data_in(tx_data[g]),
        .bit_q(pat_bit[g])
      );

      stpc_taps u_taps (
        .pclk(pclk),
        .presetn(presetn),
        .byte_clk(byte_clk[g]),
        .update(lane_q[g].tap_weight_update),
        .post_code(lane_q[g].post_cursor_weight),
        .pre_code(lane_q[g].pre_cursor_weight),
        .post_weight_q(lane_out[g].post_weight),
        .pre_weight_q(lane_out[g].pre_weight)
      );

      assign lane_out[g].transmitter_on = lane_q[g].transmitter_on; // [RULE14]
      // Driver is dark when the lane is off or in the driver-off loopback.
      assign lane_out[g].driver_on = lane_q[g].transmitter_on && (lane_q[g].loopback != stpc_pkg::LB_DRV_OFF); // [RULE7]
      // The reserved loopback code is treated as no loopback.
      assign lane_out[g].loopback_on = lane_q[g].loopback[1]; // [RULE7]
      assign lane_out[g].lane_sync_master = lane_q[g].lane_sync_master; // [RULE8]
      assign lane_out[g].rate = lane_q[g].rate; // [RULE13]
      assign lane_out[g].parallel_width_select = lane_q[g].parallel_width_select; // [RULE15]
      assign lane_out[g].swing = lane_q[g].swing;
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txp_q <= '0;
      txn_q <= '1;
    end else begin
      for (int i = 0; i < NL; i++) begin
        txp_q[i] <= pat_bit[i] ^ lane_q[i].pair_polarity_swap; // [RULE12]
        txn_q[i] <= ~(pat_bit[i] ^ lane_q[i].pair_polarity_swap); // [RULE12]
      end
    end
  end

  assign tx_p = txp_q;
  assign tx_n = txn_q;
  assign peripheral_on = peripheral_on_q; // [RULE21]
  assign local_rx_accept = local_accept_q;
  assign emu_soft = soft_q;
  assign emu_free = free_q;
  assign settings_out = set_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_id_read;
    (rd_setup && hit_id) |=> (prdata == stpc_pkg::ID_VALUE);
  endproperty
  a_id_read: assert property (p_id_read) else $error("identification word read wrong"); // [RULE17]

  property p_id_write_inert;
    (wr_en && hit_id) |=> ($stable(set_q) && $stable(peripheral_on_q) && $stable(user_q));
  endproperty
  a_id_write_inert: assert property (p_id_write_inert) else $error("write to identification changed state"); // [RULE16]

  property p_restore_gated;
    (wr_en && hit_ctrl && pstrb[0] && pwdata[stpc_pkg::CTRL_RESTORE_BIT] && !peripheral_on_q && !local_accept_q)
      |=> !local_accept_q;
  endproperty
  a_restore_gated: assert property (p_restore_gated) else $error("restore acted while peripheral off"); // [RULE18]

  property p_restore_sets;
    (restore_pulse && module_rst_n) |=> local_accept_q;
  endproperty
  a_restore_sets: assert property (p_restore_sets) else $error("restore did not re-allow local traffic"); // [RULE19]

  property p_module_reset_discards;
    !module_rst_n |=> !local_rx_accept;
  endproperty
  a_module_reset_discards: assert property (p_module_reset_discards) else $error("local traffic accepted in reset"); // [RULE20]

  property p_peripheral_on_write;
    (wr_en && hit_ctrl && pstrb[0]) |=> (peripheral_on == $past(pwdata[stpc_pkg::CTRL_PERIPHERAL_ON_BIT]));
  endproperty
  a_peripheral_on_write: assert property (p_peripheral_on_write) else $error("peripheral on did not follow write"); // [RULE21]

  sequence s_lane0_drv_off;
    wr_en && hit_lane[0] && (pstrb[2] == 1'b1) && (pwdata[22:21] == stpc_pkg::LB_DRV_OFF);
  endsequence
  property p_loop_drv_off;
    s_lane0_drv_off |=> (!lane_out[0].driver_on && lane_out[0].loopback_on);
  endproperty
  a_loop_drv_off: assert property (p_loop_drv_off) else $error("driver-off loopback not applied"); // [RULE7]

  property p_tap_hold;
    !(byte_clk[0] && lane_q[0].tap_weight_update) |=> $stable(lane_out[0].post_weight);
  endproperty
  a_tap_hold: assert property (p_tap_hold) else $error("tap weight moved without update"); // [RULE9]

  property p_post_decode;
    (byte_clk[0] && lane_q[0].tap_weight_update)
      |=> (lane_out[0].post_weight == stpc_pkg::post_weight_f($past(lane_q[0].post_cursor_weight)));
  endproperty
  a_post_decode: assert property (p_post_decode) else $error("post-cursor weight wrong"); // [RULE10]

  property p_pre_decode;
    (byte_clk[0] && lane_q[0].tap_weight_update)
      |=> (lane_out[0].pre_weight == stpc_pkg::pre_weight_f($past(lane_q[0].pre_cursor_weight)));
  endproperty
  a_pre_decode: assert property (p_pre_decode) else $error("pre-cursor weight wrong"); // [RULE11]

  property p_pair_complement;
    (tx_n == ~tx_p);
  endproperty
  a_pair_complement: assert property (p_pair_complement) else $error("lane pair not complementary"); // [RULE12]

  property p_pol_swap;
    (lane_q[0].pair_polarity_swap && $stable(lane_q[0].pair_polarity_swap)) |=> (tx_p[0] == ~$past(pat_bit[0]));
  endproperty
  a_pol_swap: assert property (p_pol_swap) else $error("polarity swap not applied"); // [RULE12]

  property p_tx_off;
    !lane_q[0].transmitter_on |-> (!lane_out[0].transmitter_on && !lane_out[0].driver_on);
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("lane on while disabled"); // [RULE14]

  property p_unmapped_err;
    (psel && penable && !mapped) |-> (pslverr && pready);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not flagged"); // [RULE16]

endmodule

//--- common/stpc_pkg.sv
// Constants, field layouts and carrier types for the lane transmit and peripheral control block.
// Assumes byte addressing on a 32-bit APB bus, one aligned word per register.
package stpc_pkg;

  localparam int unsigned NUM_LANES = 4;

  localparam logic [31:0] ADDR_ID = 32'h0000_0000;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0004;
  localparam logic [31:0] ADDR_SET = 32'h0000_0014;
  localparam logic [31:0] ADDR_USER = 32'h0000_0020;
  localparam logic [31:0] ADDR_LANE_BASE = 32'h0262_0368;
  localparam logic [31:0] LANE_STRIDE = 32'h0000_0008;

  localparam int unsigned CTRL_FREE_BIT = 0;
  localparam int unsigned CTRL_SOFT_BIT = 1;
  localparam int unsigned CTRL_PERIPHERAL_ON_BIT = 2;
  localparam int unsigned CTRL_LOCAL_BIT = 3;
  localparam int unsigned CTRL_RESTORE_BIT = 4;
  localparam logic CTRL_FREE_RST = 1'b1;
  localparam logic CTRL_SOFT_RST = 1'b0;
  localparam logic CTRL_PERIPHERAL_ON_RST = 1'b0;
  localparam logic CTRL_LOCAL_RST = 1'b0;

  localparam logic [31:0] SET_RST = 32'h0005_3800;
  localparam logic [31:0] SET_WMASK = 32'hffff_feff;
  localparam logic [19:0] USER_RST = 20'h66666;
  localparam logic [31:0] LANE_RST = 32'h0000_0004;
  localparam logic [31:0] LANE_WMASK = 32'h03ff_ffff;
  localparam logic [4:0] USER_LAST = 5'h13;

  localparam logic [2:0] TP_OFF = 3'h0;
  localparam logic [2:0] TP_ALT = 3'h1;
  localparam logic [2:0] TP_PRBS7 = 3'h2;
  localparam logic [2:0] TP_PRBS23 = 3'h3;
  localparam logic [2:0] TP_PRBS31 = 3'h4;
  localparam logic [2:0] TP_USER = 3'h5;

  localparam logic [1:0] LB_OFF = 2'h0;
  localparam logic [1:0] LB_RSVD = 2'h1;
  localparam logic [1:0] LB_DRV_OFF = 2'h2;
  localparam logic [1:0] LB_DRV_ON = 2'h3;

  // Identification fields; every value except the scheme is arbitrary.
  localparam logic [1:0] ID_SCHEME = 2'h1;
  localparam logic [1:0] ID_UNIT = 2'h2;
  localparam logic [11:0] ID_FUNC = 12'h5a5;
  localparam logic [4:0] ID_RELEASE = 5'h01;
  localparam logic [2:0] ID_MAJOR = 3'h1;
  localparam logic [1:0] ID_CUSTOM = 2'h0;
  localparam logic [5:0] ID_MINOR = 6'h00;
  localparam logic [31:0] ID_VALUE = {ID_SCHEME, ID_UNIT, ID_FUNC, ID_RELEASE, ID_MAJOR, ID_CUSTOM, ID_MINOR};

  typedef struct packed {
    logic [5:0] reserved;
    logic [2:0] test_sequence_select;
    logic [1:0] loopback;
    logic lane_sync_master;
    logic tap_weight_update;
    logic [4:0] post_cursor_weight;
    logic [2:0] pre_cursor_weight;
    logic [3:0] swing;
    logic pair_polarity_swap;
    logic [1:0] rate;
    logic [2:0] parallel_width_select;
    logic transmitter_on;
  } stpc_lane_cfg_t;

  typedef struct packed {
    logic transmitter_on;
    logic driver_on;
    logic loopback_on;
    logic lane_sync_master;
    logic [1:0] rate;
    logic [2:0] parallel_width_select;
    logic [3:0] swing;
    logic signed [5:0] post_weight;
    logic signed [3:0] pre_weight;
  } stpc_lane_out_t;

  // Post-cursor weight in 2.5 % steps: top bit is the sign, low four bits the magnitude.
  function automatic logic signed [5:0] post_weight_f(input logic [4:0] code);
    logic signed [5:0] mag;
    mag = $signed({2'h0, code[3:0]});
    post_weight_f = code[4] ? -mag : mag;
  endfunction

  // Pre-cursor weight in 2.5 % steps, never positive.
  function automatic logic signed [3:0] pre_weight_f(input logic [2:0] code);
    pre_weight_f = -$signed({1'h0, code});
  endfunction

endpackage

//--- verilog/stpc_pattern.sv
// Per-lane serial bit source: mission data or one of the test sequences, one bit per clock.
// Assumes one unit interval per pclk cycle; the serialiser outside stretches it to line rate.
`timescale 1ns/10ps
module stpc_pattern (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] sel,
  input wire logic [19:0] user_bits,
  input wire logic data_in,
  output logic bit_q
);

  logic [6:0] prbs7_q;
  logic [22:0] prbs23_q;
  logic [30:0] prbs31_q;
  logic [4:0] user_idx_q;
  logic alt_q;
  logic bit_d;

  // The generators free-run so that a mode switch never starts from a stuck all-zero state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prbs7_q <= 7'h7f;
      prbs23_q <= 23'h7fffff;
      prbs31_q <= 31'h7fffffff;
    end else begin
      prbs7_q <= {prbs7_q[5:0], prbs7_q[6] ^ prbs7_q[5]}; // [RULE2]
      prbs23_q <= {prbs23_q[21:0], prbs23_q[22] ^ prbs23_q[17]}; // [RULE3]
      prbs31_q <= {prbs31_q[29:0], prbs31_q[30] ^ prbs31_q[27]}; // [RULE4]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_idx_q <= 5'h00;
      alt_q <= 1'b0;
    end else begin
      user_idx_q <= (user_idx_q == stpc_pkg::USER_LAST) ? 5'h00 : user_idx_q + 5'h01; // [RULE5]
      alt_q <= ~alt_q; // [RULE6]
    end
  end

  always_comb begin
    unique case (sel) // [RULE1]
      stpc_pkg::TP_OFF: bit_d = data_in;
      stpc_pkg::TP_ALT: bit_d = alt_q;
      stpc_pkg::TP_PRBS7: bit_d = prbs7_q[6];
      stpc_pkg::TP_PRBS23: bit_d = prbs23_q[22];
      stpc_pkg::TP_PRBS31: bit_d = prbs31_q[30];
      stpc_pkg::TP_USER: bit_d = user_bits[user_idx_q];
      default: bit_d = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_q <= 1'b0;
    end else begin
      bit_q <= bit_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_prbs7_held;
    (sel == stpc_pkg::TP_PRBS7) [*8];
  endsequence
  property p_prbs7_recur;
    s_prbs7_held |=> (bit_q == ($past(bit_q, 7) ^ $past(bit_q, 6)));
  endproperty
  a_prbs7_recur: assert property (p_prbs7_recur) else $error("short PRBS breaks its recurrence"); // [RULE2]

  property p_alt_toggle;
    (sel == stpc_pkg::TP_ALT) [*2] |=> (bit_q != $past(bit_q));
  endproperty
  a_alt_toggle: assert property (p_alt_toggle) else $error("alternating pattern did not toggle"); // [RULE6]

  property p_off_passes_data;
    (sel == stpc_pkg::TP_OFF) |=> (bit_q == $past(data_in));
  endproperty
  a_off_passes_data: assert property (p_off_passes_data) else $error("mission data not passed"); // [RULE1]

  property p_reserved_quiet;
    (sel[2:1] == 2'h3) |=> !bit_q;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved code drove a one"); // [RULE1]

endmodule

//--- verilog/stpc_taps.sv
// Transmit filter tap weight holding register for one lane.
// Assumes the lane byte clock arrives as a level synchronous to pclk.
`timescale 1ns/10ps
module stpc_taps (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic byte_clk,
  input wire logic update,
  input wire logic [4:0] post_code,
  input wire logic [2:0] pre_code,
  output logic signed [5:0] post_weight_q,
  output logic signed [3:0] pre_weight_q
);

  // Loading only while both levels are high keeps the analog filter from seeing half-written codes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_weight_q <= 6'sh00;
      pre_weight_q <= 4'sh0;
    end else if (byte_clk && update) begin // [RULE9]
      post_weight_q <= stpc_pkg::post_weight_f(post_code); // [RULE10]
      pre_weight_q <= stpc_pkg::pre_weight_f(pre_code); // [RULE11]
    end
  end

endmodule

//--- bench/stpc_macro_model.sv
// Far-side model: lane byte clocks, mission bits and the incoming module reset.
// Assumes all of it is synchronous to pclk.
`timescale 1ns/10ps
module stpc_macro_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bclk_run,
  input wire logic core_hold,
  output logic [3:0] byte_clk,
  output logic [3:0] tx_data,
  output logic module_rst_n
);
  // The byte clock stands low unless asked to run, so a tap load can be starved on purpose.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_clk <= 4'h0;
      tx_data <= 4'h0;
      module_rst_n <= 1'h0;
    end else begin
      byte_clk <= bclk_run ? ~byte_clk : 4'h0;
      tx_data <= {tx_data[2:0], ~tx_data[3]};
      module_rst_n <= ~core_hold;
    end
  end
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the lane transmit and peripheral control register bank.
// Assumes the zero-wait APB slave and the lane timing given by the designer.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, bclk_run, core_hold, err;
  logic [31:0] paddr, pwdata, prdata, settings_out, rd;
  logic [3:0] pstrb, byte_clk, tx_data, tx_p, tx_n;
  logic pready, pslverr, peripheral_on, local_rx_accept, emu_soft, emu_free, module_rst_n;
  stpc_pkg::stpc_lane_out_t [3:0] lane_out;
  stpc_pkg::stpc_lane_cfg_t cfg;
  logic [63:0] strm;
  int num_errors = 0;
  int comparisons = 0;

  stpc_top stpc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .byte_clk(byte_clk), .tx_data(tx_data), .module_rst_n(module_rst_n), .tx_p(tx_p), .tx_n(tx_n),
    .lane_out(lane_out), .peripheral_on(peripheral_on), .local_rx_accept(local_rx_accept),
    .emu_soft(emu_soft), .emu_free(emu_free), .settings_out(settings_out));
  stpc_macro_model stpc_macro_model_i (.pclk(pclk), .presetn(presetn), .bclk_run(bclk_run),
    .core_hold(core_hold), .byte_clk(byte_clk), .tx_data(tx_data), .module_rst_n(module_rst_n));

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Callers look at register outputs only once the write has settled.
    @(negedge pclk);
  endtask

  task automatic lane(input logic [2:0] tp, input logic [1:0] lb, input logic upd, input logic [4:0] post,
    input logic [2:0] pre, input logic inv);
    cfg = '0;
    cfg.test_sequence_select = tp;
    cfg.loopback = lb;
    cfg.rate = lb;
    cfg.lane_sync_master = 1'h1;
    cfg.tap_weight_update = upd;
    cfg.post_cursor_weight = post;
    cfg.pre_cursor_weight = pre;
    cfg.pair_polarity_swap = inv;
    cfg.parallel_width_select = 3'h2;
    cfg.transmitter_on = (lb != 2'h1);
    apb(1'h1, stpc_pkg::ADDR_LANE_BASE, cfg);
  endtask

  task automatic grab();
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 64; i++) begin
      @(negedge pclk);
      strm[i] = tx_p[0];
      `CHK("pair", ~tx_p[0], tx_n[0])
    end
  endtask

  task automatic t_regs();
    apb(1'h1, stpc_pkg::ADDR_ID, 32'hffff_ffff);
    apb(1'h0, stpc_pkg::ADDR_ID, 32'h0);
    `CHK("id", stpc_pkg::ID_VALUE, rd)
    `CHK("scheme", 2'h1, rd[31:30])
    apb(1'h0, stpc_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, rd)
    apb(1'h0, stpc_pkg::ADDR_USER, 32'h0);
    `CHK("user", 32'h66666, rd)
    `CHK("settings", stpc_pkg::SET_RST, settings_out)
    apb(1'h0, 32'h8, 32'h0);
    `CHK("unmapped", 1'h1, err)
    $display("Registers done");
  endtask

  task automatic t_ctrl();
    apb(1'h1, stpc_pkg::ADDR_CTRL, 32'h10);
    `CHK("restore off", 1'h0, local_rx_accept)
    `CHK("on", 1'h0, peripheral_on)
    apb(1'h1, stpc_pkg::ADDR_CTRL, 32'h7);
    `CHK("on", 1'h1, peripheral_on)
    `CHK("soft", 1'h1, emu_soft)
    `CHK("free", 1'h1, emu_free)
    apb(1'h1, stpc_pkg::ADDR_CTRL, 32'h15);
    `CHK("restore", 1'h1, local_rx_accept)
    apb(1'h0, stpc_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl", 32'hd, rd)
    core_hold <= 1'h1;
    repeat (3) @(posedge pclk);
    `CHK("discard", 1'h0, local_rx_accept)
    core_hold <= 1'h0;
    $display("Control done");
  endtask

  task automatic t_seq();
    int len [3] = '{7, 23, 31};
    int tap [3] = '{6, 18, 28};
    logic [19:0] pat;
    logic hit;
    for (int k = 0; k < 3; k++) begin
      lane(3'h2 + 3'(k), 2'h0, 1'h0, 5'h0, 3'h0, 1'h0);
      grab();
      `CHK("live", 1'h1, |strm)
      for (int i = 0; i + len[k] < 64; i++)
        `CHK("prbs", strm[i] ^ strm[i + len[k] - tap[k]], strm[i + len[k]])
    end
    lane(3'h1, 2'h0, 1'h0, 5'h0, 3'h0, 1'h1);
    grab();
    for (int i = 0; i < 63; i++)
      `CHK("alt", ~strm[i], strm[i + 1])
    lane(3'h6, 2'h0, 1'h0, 5'h0, 3'h0, 1'h0);
    grab();
    `CHK("reserved", 64'h0, strm)
    lane(3'h0, 2'h0, 1'h0, 5'h0, 3'h0, 1'h0);
    grab();
    `CHK("mission", ~strm[59:0], strm[63:4])
    apb(1'h1, stpc_pkg::ADDR_USER, 32'he3a5c);
    for (int v = 0; v < 2; v++) begin
      lane(3'h5, 2'h0, 1'h0, 5'h0, 3'h0, 1'(v));
      grab();
      pat = 20'he3a5c ^ {20{1'(v)}};
      hit = 1'h0;
      for (int s = 0; s < 20; s++)
        if (strm[s +: 20] === pat && strm[s + 20 +: 20] === pat) hit = 1'h1;
      `CHK("user", 1'h1, hit)
    end
    $display("Sequences done");
  endtask

  task automatic t_lane();
    lane(3'h0, 2'h0, 1'h1, 5'h13, 3'h7, 1'h0);
    repeat (4) @(posedge pclk);
    `CHK("post idle", 6'h0, lane_out[0].post_weight)
    bclk_run <= 1'h1;
    repeat (4) @(posedge pclk);
    `CHK("post", 6'h3d, lane_out[0].post_weight)
    `CHK("pre", 4'h9, lane_out[0].pre_weight)
    lane(3'h0, 2'h0, 1'h0, 5'h0f, 3'h0, 1'h0);
    repeat (4) @(posedge pclk);
    `CHK("post held", 6'h3d, lane_out[0].post_weight)
    bclk_run <= 1'h0;
    for (int b = 0; b < 4; b++) begin
      lane(3'h0, 2'(b), 1'h0, 5'h0, 3'h0, 1'h0);
      @(negedge pclk);
      `CHK("drv", b != 1 && b != 2, lane_out[0].driver_on)
      `CHK("loop", b > 1, lane_out[0].loopback_on)
      `CHK("rate", 2'(b), lane_out[0].rate)
      `CHK("txon", b != 1, lane_out[0].transmitter_on)
      `CHK("sync", 1'h1, lane_out[0].lane_sync_master)
      `CHK("width", 3'h2, lane_out[0].parallel_width_select)
    end
    $display("Lane done");
  endtask

  task automatic wrap_up();
    $display("Checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end
  // The whole sequence needs under 700 cycles; some thirty times that means a hang.
  initial begin
    #(40 * 20000);
    num_errors++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, bclk_run, core_hold} = 6'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_ctrl();
    t_seq();
    t_lane();
    wrap_up();
  end
endmodule
